// *** port4_cs_pkg.sv ***
// Purpose: shared constants and types for the port 4 chip-select decoder
// Assumes: 8-bit special function register space, 16-bit external bus address
// Notes:   unlisted register offsets are parameters of the top module
package port4_cs_pkg;

	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] CTRL_A_OFS   = 8'hc2;
	localparam logic [7:0] CTRL_B_OFS   = 8'hc3;
	localparam logic [7:0] POLARITY_OFS = 8'hae;
	localparam logic [7:0] PIN2_LO_OFS  = 8'hac;
	localparam logic [7:0] PIN2_HI_OFS  = 8'had;
	localparam logic [7:0] PIN3_LO_OFS  = 8'hb4;
	localparam logic [7:0] PIN3_HI_OFS  = 8'hb5;

	// ------------------------------------------------------------
	// field layout and reset values
	// ------------------------------------------------------------
	localparam int         NUM_PINS     = 4;
	localparam int         FIELD_STRIDE = 4;   // pin i owns bits of {ctrl_b, ctrl_a}
	localparam int         FUNC_OFS     = 2;
	localparam int         CMP_OFS      = 0;
	localparam int         POL_OFS      = 4;   // polarity bits sit in 7:4
	localparam logic [7:0] CTRL_RST     = 8'h00;
	localparam logic [3:0] POL_RST      = 4'h0;
	localparam logic [7:0] BASE_RST     = 8'h00;
	localparam logic [3:0] LATCH_RST    = 4'hf;  // port latches idle high like port 1
	localparam logic [7:0] RDATA_RST    = 8'h00;

	// ------------------------------------------------------------
	// encodings
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		FUNC_GPIO  = 2'h0,
		FUNC_RD    = 2'h1,
		FUNC_WR    = 2'h2,
		FUNC_RDWR  = 2'h3
	} pin_func_t;

	typedef enum logic [1:0] {
		CMP_FULL16 = 2'h0,
		CMP_MSB15  = 2'h1,
		CMP_MSB14  = 2'h2,
		CMP_MSB8   = 2'h3
	} cmp_len_t;

endpackage : port4_cs_pkg

// *** addr_cmp_if.sv ***
// Purpose: carries one pin's comparator settings and the match answer
// Assumes: combinational comparator, same clock domain on both sides
// Notes:   one instance per port 4 pin
`timescale 1ns/10ps
interface addr_cmp_if;
	logic [1:0]  cmp_len;
	logic [7:0]  base_hi;
	logic [7:0]  base_lo;
	logic [15:0] bus_addr;
	logic        match;

	modport cmp  (input cmp_len, input base_hi, input base_lo, input bus_addr, output match);
	modport user (output cmp_len, output base_hi, output base_lo, output bus_addr, input match);
endinterface : addr_cmp_if

// *** addr_range_cmp.sv ***
// Purpose: address range match for one strobe pin
// Assumes: settings are stable register outputs
// Notes:   purely combinational, the top registers the result
`timescale 1ns/10ps
module addr_range_cmp (
	addr_cmp_if.cmp port
);
	import port4_cs_pkg::*;

	// ------------------------------------------------------------
	// masked compare
	// ------------------------------------------------------------
	always_comb begin
		case (cmp_len_t'(port.cmp_len))
			CMP_FULL16: port.match = (port.bus_addr == {port.base_hi, port.base_lo});
			CMP_MSB15:  port.match = (port.bus_addr[15:1] == {port.base_hi, port.base_lo[7:1]});
			CMP_MSB14:  port.match = (port.bus_addr[15:2] == {port.base_hi, port.base_lo[7:2]});
			CMP_MSB8:   port.match = (port.bus_addr[15:8] == port.base_hi);
			default:    port.match = 1'b0;
		endcase
	end
endmodule : addr_range_cmp

// *** port4_chip_select_decoder.sv ***
// Purpose: function select and chip-select strobes for the four port 4 pins
// Assumes: sfr access and external bus strobes come from core logic on clk
// Notes:   strobes and pin drive are registered, one clock behind the bus
//
// Operation
// - function 00: pin is plain quasi-bidirectional port pin, no strobe
// - function 01: strobe only on external reads inside the range
// - function 10: strobe only on external writes inside the range
// - function 11: strobe on external reads and writes inside the range
// - range comes from the pin's own base bytes and compare length
// - length 00 compares all sixteen address bits
// - length 01 ignores address bit 0
// - length 10 ignores address bits 1 and 0
// - length 11 compares only upper byte with high base byte
// - control b: pin 3 in bits 7:4, pin 2 in bits 3:0
// - control a: pin 1 function 7:6, length 5:4
// - control a: pin 0 function 3:2, length 1:0
// - polarity bits 7:4 choose active high strobe, low bits zero
// - each strobe pin has its own low and high base byte
`timescale 1ns/10ps
module port4_chip_select_decoder #(
	parameter logic [7:0] PIN0_LO_OFS = 8'ha4,
	parameter logic [7:0] PIN0_HI_OFS = 8'ha5,
	parameter logic [7:0] PIN1_LO_OFS = 8'ha6,
	parameter logic [7:0] PIN1_HI_OFS = 8'ha7,
	parameter logic [7:0] LATCH_OFS   = 8'hd8
) (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic [7:0]  sfr_addr,
	input  wire logic        sfr_wr,
	input  wire logic        sfr_rd,
	input  wire logic [7:0]  sfr_wdata,
	output logic      [7:0]  sfr_rdata,
	input  wire logic [15:0] ext_addr,
	input  wire logic        ext_rd_n,
	input  wire logic        ext_wr_n,
	input  wire logic [3:0]  p4_in,
	output logic      [3:0]  p4_out,
	output logic      [3:0]  p4_oe
);
	import port4_cs_pkg::*;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0]      ctrl_a;
		logic [7:0]      ctrl_b;
		logic [3:0]      pol;
		logic [3:0][7:0] base_lo;
		logic [3:0][7:0] base_hi;
		logic [3:0]      latch;
		logic [3:0]      act;
		logic [3:0]      pin_out;
		logic [3:0]      pin_oe;
		logic [7:0]      rdata;
		logic [3:0]      sync1;
		logic [3:0]      sync2;
	} state_t;

	state_t      st_ff;
	state_t      nxt_st;
	logic [15:0] ctrl_all;
	logic [3:0]  match;
	logic [7:0]  lo_ofs [NUM_PINS];
	logic [7:0]  hi_ofs [NUM_PINS];

	assign ctrl_all = {st_ff.ctrl_b, st_ff.ctrl_a};
	assign lo_ofs   = '{PIN0_LO_OFS, PIN1_LO_OFS, PIN2_LO_OFS, PIN3_LO_OFS};
	assign hi_ofs   = '{PIN0_HI_OFS, PIN1_HI_OFS, PIN2_HI_OFS, PIN3_HI_OFS};

	function automatic logic [1:0] func_of(input logic [15:0] c, input int i);
		func_of = c[i*FIELD_STRIDE+FUNC_OFS +: 2];
	endfunction : func_of

	function automatic logic [1:0] cmp_of(input logic [15:0] c, input int i);
		cmp_of = c[i*FIELD_STRIDE+CMP_OFS +: 2];
	endfunction : cmp_of

	// ------------------------------------------------------------
	// one comparator per pin
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < NUM_PINS; g++) begin : g_cmp
			addr_cmp_if cif ();
			assign cif.cmp_len  = cmp_of(ctrl_all, g);
			assign cif.base_hi  = st_ff.base_hi[g];
			assign cif.base_lo  = st_ff.base_lo[g];
			assign cif.bus_addr = ext_addr;
			assign match[g]     = cif.match;
			addr_range_cmp u_cmp (
				.port (cif.cmp)
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// next state: register writes, reads, strobes, pin drive
	// ------------------------------------------------------------
	always_comb begin
		logic       hit_rd;
		logic       hit_wr;
		logic [1:0] fn;
		hit_rd = 1'b0;
		hit_wr = 1'b0;
		fn     = 2'h0;
		nxt_st = st_ff;
		// pin levels come from outside, two flops before use
		nxt_st.sync1 = p4_in;
		nxt_st.sync2 = st_ff.sync1;
		if (sfr_wr) begin
			if (sfr_addr == CTRL_A_OFS)   nxt_st.ctrl_a = sfr_wdata;
			if (sfr_addr == CTRL_B_OFS)   nxt_st.ctrl_b = sfr_wdata;
			if (sfr_addr == POLARITY_OFS) nxt_st.pol = sfr_wdata[7:POL_OFS];
			if (sfr_addr == LATCH_OFS)    nxt_st.latch = sfr_wdata[3:0];
			for (int i = 0; i < NUM_PINS; i++) begin
				if (sfr_addr == lo_ofs[i]) nxt_st.base_lo[i] = sfr_wdata;
				if (sfr_addr == hi_ofs[i]) nxt_st.base_hi[i] = sfr_wdata;
			end
		end
		// read data held until the next read; unmapped reads give zero
		if (sfr_rd) begin
			nxt_st.rdata = RDATA_RST;
			if (sfr_addr == CTRL_A_OFS)   nxt_st.rdata = st_ff.ctrl_a;
			if (sfr_addr == CTRL_B_OFS)   nxt_st.rdata = st_ff.ctrl_b;
			if (sfr_addr == POLARITY_OFS) nxt_st.rdata = {st_ff.pol, 4'h0};
			if (sfr_addr == LATCH_OFS)    nxt_st.rdata = {4'h0, st_ff.sync2};
			for (int i = 0; i < NUM_PINS; i++) begin
				if (sfr_addr == lo_ofs[i]) nxt_st.rdata = st_ff.base_lo[i];
				if (sfr_addr == hi_ofs[i]) nxt_st.rdata = st_ff.base_hi[i];
			end
		end
		for (int i = 0; i < NUM_PINS; i++) begin
			fn     = func_of(ctrl_all, i);
			hit_rd = !ext_rd_n && match[i];
			hit_wr = !ext_wr_n && match[i];
			case (pin_func_t'(fn))
				FUNC_RD:   nxt_st.act[i] = hit_rd;
				FUNC_WR:   nxt_st.act[i] = hit_wr;
				FUNC_RDWR: nxt_st.act[i] = hit_rd || hit_wr;
				default:   nxt_st.act[i] = 1'b0;
			endcase
			if (fn == FUNC_GPIO) begin
				// quasi-bidirectional: pull low hard, release for high
				nxt_st.pin_out[i] = st_ff.latch[i];
				nxt_st.pin_oe[i]  = !st_ff.latch[i];
			end else begin
				nxt_st.pin_out[i] = st_ff.pol[i] ? nxt_st.act[i] : !nxt_st.act[i];
				nxt_st.pin_oe[i]  = 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			st_ff.ctrl_a  <= CTRL_RST;
			st_ff.ctrl_b  <= CTRL_RST;
			st_ff.pol     <= POL_RST;
			st_ff.base_lo <= {NUM_PINS{BASE_RST}};
			st_ff.base_hi <= {NUM_PINS{BASE_RST}};
			st_ff.latch   <= LATCH_RST;
			st_ff.act     <= 4'h0;
			st_ff.pin_out <= LATCH_RST;
			st_ff.pin_oe  <= 4'h0;
			st_ff.rdata   <= RDATA_RST;
			st_ff.sync1   <= 4'h0;
			st_ff.sync2   <= 4'h0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign sfr_rdata = st_ff.rdata;
	assign p4_out    = st_ff.pin_out;
	assign p4_oe     = st_ff.pin_oe;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	generate
		for (g = 0; g < NUM_PINS; g++) begin : g_chk
			property p_gpio_pin;
				@(posedge clk) disable iff (reset)
				func_of(ctrl_all, g) == FUNC_GPIO |=> !st_ff.act[g] && p4_oe[g] == !$past(st_ff.latch[g]);
			endproperty
			a_gpio_pin: assert property (p_gpio_pin) else $error("port pin mode drove a strobe");

			property p_read_only;
				@(posedge clk) disable iff (reset)
				func_of(ctrl_all, g) == FUNC_RD |=> st_ff.act[g] == $past(!ext_rd_n && match[g]);
			endproperty
			a_read_only: assert property (p_read_only) else $error("read strobe wrong");

			property p_write_only;
				@(posedge clk) disable iff (reset)
				func_of(ctrl_all, g) == FUNC_WR |=> st_ff.act[g] == $past(!ext_wr_n && match[g]);
			endproperty
			a_write_only: assert property (p_write_only) else $error("write strobe wrong");

			property p_read_write;
				@(posedge clk) disable iff (reset)
				func_of(ctrl_all, g) == FUNC_RDWR && (!ext_rd_n || !ext_wr_n) && match[g] |=> st_ff.act[g];
			endproperty
			a_read_write: assert property (p_read_write) else $error("read/write strobe missing");

			property p_polarity;
				@(posedge clk) disable iff (reset)
				func_of(ctrl_all, g) != FUNC_GPIO ##1 $stable(st_ff.pol[g])
					|-> p4_oe[g] && p4_out[g] == (st_ff.pol[g] ~^ st_ff.act[g]);
			endproperty
			a_polarity: assert property (p_polarity) else $error("strobe level ignores polarity");

			property p_idle_bus;
				@(posedge clk) disable iff (reset)
				ext_rd_n && ext_wr_n |=> !st_ff.act[g];
			endproperty
			a_idle_bus: assert property (p_idle_bus) else $error("strobe outside bus pulse");
		end
	endgenerate

	property p_full_match;
		@(posedge clk) disable iff (reset)
		cmp_of(ctrl_all, 3) == CMP_FULL16 && ext_addr != {st_ff.base_hi[3], st_ff.base_lo[3]} |-> !match[3];
	endproperty
	a_full_match: assert property (p_full_match) else $error("full compare matched wrong address");

	property p_msb15;
		@(posedge clk) disable iff (reset)
		cmp_of(ctrl_all, 2) == CMP_MSB15 && ext_addr[15:1] == {st_ff.base_hi[2], st_ff.base_lo[2][7:1]} |-> match[2];
	endproperty
	a_msb15: assert property (p_msb15) else $error("15 bit compare missed");

	property p_msb14;
		@(posedge clk) disable iff (reset)
		cmp_of(ctrl_all, 1) == CMP_MSB14 |-> match[1] == (ext_addr[15:2] == {st_ff.base_hi[1], st_ff.base_lo[1][7:2]});
	endproperty
	a_msb14: assert property (p_msb14) else $error("14 bit compare wrong");

	property p_msb8;
		@(posedge clk) disable iff (reset)
		cmp_of(ctrl_all, 0) == CMP_MSB8 |-> match[0] == (ext_addr[15:8] == st_ff.base_hi[0]);
	endproperty
	a_msb8: assert property (p_msb8) else $error("8 bit compare wrong");

	property p_ctrl_b_write;
		@(posedge clk) disable iff (reset)
		sfr_wr && sfr_addr == CTRL_B_OFS |=> func_of(ctrl_all, 3) == $past(sfr_wdata[7:6])
			&& cmp_of(ctrl_all, 2) == $past(sfr_wdata[1:0]);
	endproperty
	a_ctrl_b_write: assert property (p_ctrl_b_write) else $error("control b fields misplaced");

	property p_ctrl_a_write;
		@(posedge clk) disable iff (reset)
		sfr_wr && sfr_addr == CTRL_A_OFS |=> func_of(ctrl_all, 1) == $past(sfr_wdata[7:6])
			&& cmp_of(ctrl_all, 0) == $past(sfr_wdata[1:0]);
	endproperty
	a_ctrl_a_write: assert property (p_ctrl_a_write) else $error("control a fields misplaced");

	property p_reset_zero;
		@(posedge clk) $fell(reset) |-> ctrl_all == 16'h0000 && st_ff.act == 4'h0;
	endproperty
	a_reset_zero: assert property (p_reset_zero) else $error("fields not zero after reset");

	c_read_strobe:  cover property (@(posedge clk) disable iff (reset) func_of(ctrl_all, 3) == FUNC_RD && st_ff.act[3]);
	c_write_strobe: cover property (@(posedge clk) disable iff (reset) func_of(ctrl_all, 2) == FUNC_WR && st_ff.act[2]);
	c_active_high:  cover property (@(posedge clk) disable iff (reset) st_ff.pol[1] && st_ff.act[1]);
	c_msb8_hit:     cover property (@(posedge clk) disable iff (reset) cmp_of(ctrl_all, 0) == CMP_MSB8 && match[0]);

endmodule : port4_chip_select_decoder

// *** periph_pin_model.sv ***
// Purpose: far side of the port 4 pins, peripherals hanging on the strobes
// Assumes: a released pin floats to its pull-up
// Notes:   pull_low lets the bench pull a released pin low from outside
`timescale 1ns/10ps
module periph_pin_model (
	input  wire logic [3:0] pin_out,
	input  wire logic [3:0] pin_oe,
	input  wire logic [3:0] pull_low,
	output logic      [3:0] pin_level
);
	// ------------------------------------------------------------
	// pin resolution
	// ------------------------------------------------------------
	// the model never echoes a stale level; released means pull-up unless pull_low holds the pin low
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			pin_level[i] = pin_oe[i] ? pin_out[i] : !pull_low[i];
		end
	end
endmodule : periph_pin_model

// *** port4_chip_select_decoder_tb.sv ***
// Purpose: register and strobe checks for the port 4 chip-select decoder
// Assumes: inputs change on the falling edge, outputs read at the next falling edge
// Notes:   pin levels are judged on the resolved wire from the pin model
`timescale 1ns/10ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
	$display("mismatch %s expected %h seen %h", nm, e, g); end end
module port4_chip_select_decoder_tb;
	import port4_cs_pkg::*;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	localparam logic [7:0] LO_OFS [4] = '{8'ha4, 8'ha6, PIN2_LO_OFS, PIN3_LO_OFS};
	localparam logic [7:0] HI_OFS [4] = '{8'ha5, 8'ha7, PIN2_HI_OFS, PIN3_HI_OFS};
	localparam logic [7:0] LATCH_ADR = 8'hd8;  // port latch offset, same value handed to the design
	localparam logic [15:0] FLIPS [5] = '{16'h0000, 16'h0001, 16'h0002, 16'h0080, 16'h0100};
	localparam logic [15:0] MASKS [4] = '{16'hffff, 16'hfffe, 16'hfffc, 16'hff00};
	logic        clk = 1'b0;
	logic        reset = 1'b1;
	logic [7:0]  sfr_addr = 8'h00;
	logic        sfr_wr = 1'b0;
	logic        sfr_rd = 1'b0;
	logic [7:0]  sfr_wdata = 8'h00;
	logic [7:0]  sfr_rdata;
	logic [15:0] ext_addr = 16'h0000;
	logic        ext_rd_n = 1'b1;
	logic        ext_wr_n = 1'b1;
	logic [3:0]  p4_in;
	logic [3:0]  p4_out;
	logic [3:0]  p4_oe;
	logic [3:0]  pull_low = 4'h0;
	int          n_mismatch = 0;
	int          samples_checked = 0;
	int          cycles = 0;

	port4_chip_select_decoder #(.PIN0_LO_OFS(8'ha4), .PIN0_HI_OFS(8'ha5), .PIN1_LO_OFS(8'ha6),
		.PIN1_HI_OFS(8'ha7), .LATCH_OFS(LATCH_ADR)) port4_chip_select_decoder_i (
		.clk(clk), .reset(reset), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
		.sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .ext_addr(ext_addr), .ext_rd_n(ext_rd_n),
		.ext_wr_n(ext_wr_n), .p4_in(p4_in), .p4_out(p4_out), .p4_oe(p4_oe));
	periph_pin_model periph_pin_model_i (.pin_out(p4_out), .pin_oe(p4_oe), .pull_low(pull_low),
		.pin_level(p4_in));

	// clock and hang guard; the full run needs about 2650 cycles
	initial begin
		forever #10 clk = !clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 10000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end

	// ------------------------------------------------------------
	// access tasks
	// ------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(negedge clk);
		sfr_wr = 1'b0;
	endtask : wr
	// read data is registered, so it is settled at the following fall
	task automatic rd(input logic [7:0] a, output logic [7:0] q);
		@(negedge clk);
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(negedge clk);
		sfr_rd = 1'b0;
		q = sfr_rdata;
	endtask : rd
	task automatic bus(input logic [15:0] a, input logic r_n, input logic w_n);
		@(negedge clk);
		ext_addr = a;
		ext_rd_n = r_n;
		ext_wr_n = w_n;
		@(negedge clk);
	endtask : bus
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : tally_and_finish

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		logic [7:0]  q;
		logic [15:0] c;
		logic [15:0] base;
		logic [15:0] a;
		logic [3:0]  exp_lvl;
		logic        act;
		repeat (20) @(negedge clk);
		reset = 1'b0;
		`CHK("oe after reset", 4'h0, p4_oe)
		`CHK("out after reset", 4'hf, p4_out)
		rd(CTRL_A_OFS, q);
		`CHK("ctrl a reset", 8'h00, q)
		rd(CTRL_B_OFS, q);
		`CHK("ctrl b reset", 8'h00, q)
		// distinct bases per pin prove each pin owns its own pair
		for (int i = 0; i < 4; i++) begin
			rd(LO_OFS[i], q);
			`CHK("base lo reset", 8'h00, q)
			wr(LO_OFS[i], 8'h31 + 8'(i));
			wr(HI_OFS[i], 8'h40 + 8'(i));
		end
		for (int i = 0; i < 4; i++) begin
			rd(LO_OFS[i], q);
			`CHK("base lo", 8'h31 + 8'(i), q)
			rd(HI_OFS[i], q);
			`CHK("base hi", 8'h40 + 8'(i), q)
		end
		wr(POLARITY_OFS, 8'hff);
		rd(POLARITY_OFS, q);
		`CHK("polarity low bits", 8'hf0, q)
		wr(8'h01, 8'h5a);
		rd(8'h01, q);
		`CHK("unmapped read", 8'h00, q)
		// every pin, function and length; length bit 0 set picks active high, clear picks active low
		for (int p = 0; p < 4; p++) begin
			for (int f = 0; f < 4; f++) begin
				for (int l = 0; l < 4; l++) begin
					c = 16'(f * 4 + l) << (4 * p);
					base = {8'h40 + 8'(p), 8'h31 + 8'(p)};
					wr(CTRL_A_OFS, c[7:0]);
					wr(CTRL_B_OFS, c[15:8]);
					wr(POLARITY_OFS, l[0] ? 8'hf0 : 8'h00);
					rd(CTRL_A_OFS, q);
					`CHK("ctrl a", c[7:0], q)
					rd(CTRL_B_OFS, q);
					`CHK("ctrl b", c[15:8], q)
					for (int k = 0; k < 15; k++) begin
						a = base ^ FLIPS[k / 3];
						bus(a, k % 3 != 0, k % 3 != 1);
						act = (((a ^ base) & MASKS[l]) == 16'h0000) && ((k % 3 == 0 && f[0]) || (k % 3 == 1 && f[1]));
						exp_lvl = 4'hf;
						if (f != 0)
							exp_lvl[p] = act ? l[0] : !l[0];
						`CHK("pin level", exp_lvl, p4_in)
						`CHK("pin drive", exp_lvl[p], p4_out[p])
						`CHK("pin oe", (f != 0) ? 4'(1 << p) : 4'h0, p4_oe)
					end
				end
			end
		end
		// plain port pins: drive low only, read back the pins themselves
		wr(CTRL_A_OFS, 8'h00);
		wr(CTRL_B_OFS, 8'h00);
		wr(LATCH_ADR, 8'h05);
		@(negedge clk);
		`CHK("gpio oe", 4'ha, p4_oe)
		pull_low = 4'h4;
		repeat (3) @(negedge clk);
		rd(LATCH_ADR, q);
		`CHK("gpio pins", 4'h1, q[3:0])
		pull_low = 4'h0;
		// reset in mid-strobe must drop it at once
		wr(CTRL_B_OFS, 8'hc0);
		wr(POLARITY_OFS, 8'h00);
		bus(16'h4334, 1'b0, 1'b1);
		// latches still hold 5: pin 1 driven low, pins 0 and 2 float high, pin 3 strobes low
		`CHK("strobe before reset", 4'h5, p4_in)
		reset = 1'b1;
		@(negedge clk);
		`CHK("strobe in reset", 4'h0, p4_oe)
		reset = 1'b0;
		rd(CTRL_B_OFS, q);
		`CHK("ctrl b after reset", 8'h00, q)
		`CHK("pins after reset", 4'hf, p4_in)
		ext_rd_n = 1'b1;
		tally_and_finish();
	end
endmodule : port4_chip_select_decoder_tb
